/* File: hw/ids_core.sv */
/*
 * Execution slice: decrement/increment with skip on zero, plain
 * increment, absolute jump, inclusive OR with literal or file register.
 * Assumes file_rdata holds the file register addressed by instruction
 * bits 6:0 in the same cycle, and that writes on file_wr land by the
 * next cycle.
 */
// Contract
// RL1 - Decrement-and-skip subtracts one; result to acc if dest 0, else file
// RL2 - Zero decrement result replaces next instruction with a no-operation
// RL3 - Increment-and-skip adds one, routes by dest, skips next on zero
// RL4 - Plain increment adds one to file 0..127, routes by dest, updates zero
// RL5 - Jump puts operand in program counter 10:0, latch bits 4:3 in 12:11
// RL6 - Jump operand 0..2047, always two cycles, no status flag changes
// RL7 - OR-literal ORs acc with 8-bit literal into acc, updates zero
// RL8 - OR-with-file ORs acc and file, routes by dest, updates zero
// RL9 - Zero flag set on zero 8-bit result, cleared on nonzero result
`timescale 1ns/1ps
`default_nettype none

module ids_core
    import ids_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire ids_instr_s         instr,
    input  wire logic [DATA_W-1:0]  file_rdata,
    input  wire logic [DATA_W-1:0]  upper_jump_latch,
    output logic      [DATA_W-1:0]  acc,
    output logic                    zero_flag,
    output logic      [PC_W-1:0]    program_counter,
    output ids_fwr_s                file_wr,
    output logic                    nop_cycle,
    output logic                    retired,
    output logic                    unknown_op
);

    // ==========================================================
    // Decode
    // ==========================================================
    ids_state_s             r;
    ids_state_s             next_r;
    logic                   go;
    logic [5:0]             opc;
    logic                   dest;
    logic [FADDR_W-1:0]     fsel;
    logic [JUMP_K_W-1:0]    jump_k;
    logic [DATA_W-1:0]      lit;
    logic                   op_dec;
    logic                   op_inc;
    logic                   op_increment_file;
    logic                   op_iorf;
    logic                   op_iorl;
    logic                   op_jump;
    logic [DATA_W-1:0]      res;
    logic                   res_zero;

    assign go      = (r.phase == IDS_EXEC) && instr.valid;
    assign opc     = instr.word[INSTR_W-1:OPC_LSB];
    assign dest    = instr.word[DEST_BIT];
    assign fsel    = instr.word[FADDR_W-1:0];
    assign jump_k  = instr.word[JUMP_K_W-1:0];
    assign lit     = instr.word[DATA_W-1:0];
    assign op_dec  = (opc == OP_DECREMENT_SKIP_ZERO);
    assign op_inc  = (opc == OP_INCREMENT_SKIP_ZERO);
    assign op_increment_file = (opc == OP_INCREMENT_FILE);
    assign op_iorf = (opc == OP_OR_ACC_WITH_FILE);
    assign op_iorl = (opc == OP_OR_LITERAL_ACC);
    assign op_jump = (instr.word[INSTR_W-1:JOPC_LSB] == OP_JUMP_ABSOLUTE);

    // One result path shared by every data operation
    always_comb begin
        res = file_rdata;
        if (op_dec) begin
            res = file_rdata - 8'h01; // RL1
        end else if (op_inc || op_increment_file) begin
            res = file_rdata + 8'h01; // RL3 RL4
        end else if (op_iorf) begin
            res = r.acc | file_rdata; // RL8
        end else if (op_iorl) begin
            res = r.acc | lit; // RL7
        end
    end

    assign res_zero = (res == 8'h00); // RL9

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_r            = r;
        next_r.fwr.we     = 1'b0;
        next_r.nop_cycle  = 1'b0;
        next_r.retired    = 1'b0;
        next_r.unknown_op = 1'b0;
        case (r.phase)
            IDS_EXEC: begin
                if (instr.valid) begin
                    next_r.retired = 1'b1;
                    next_r.pc      = r.pc + 13'h0001;
                    if (op_jump) begin
                        // Flags and data untouched; fetched word discarded
                        next_r.pc = {upper_jump_latch[PAGE_HI:PAGE_LO],
                                     jump_k}; // RL5
                        next_r.phase     = IDS_FLUSH; // RL6
                        next_r.flush_inc = 1'b0;
                    end else if (op_dec || op_inc || op_increment_file || op_iorf)
                    begin
                        if (dest == DEST_ACC) begin
                            next_r.acc = res; // RL1 RL3 RL4 RL8
                        end else begin
                            next_r.fwr.we   = 1'b1; // RL1 RL3 RL4 RL8
                            next_r.fwr.addr = fsel;
                            next_r.fwr.data = res;
                        end
                        if (op_increment_file || op_iorf) begin
                            next_r.zero = res_zero; // RL4 RL8 RL9
                        end
                        if ((op_dec || op_inc) && res_zero) begin
                            // Skipped word still consumes its address
                            next_r.phase     = IDS_FLUSH; // RL2 RL3
                            next_r.flush_inc = 1'b1;
                        end
                    end else if (op_iorl) begin
                        next_r.acc  = res; // RL7
                        next_r.zero = res_zero; // RL7 RL9
                    end else begin
                        next_r.unknown_op = 1'b1;
                    end
                end
            end
            IDS_FLUSH: begin
                // Word on instr is ignored here, valid or not
                next_r.nop_cycle = 1'b1; // RL2 RL3 RL6
                next_r.phase     = IDS_EXEC;
                if (r.flush_inc) begin
                    next_r.pc = r.pc + 13'h0001;
                end
            end
            default: begin
                next_r.phase = IDS_EXEC;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            r            <= '0;
            r.phase      <= IDS_EXEC;
            r.acc        <= RST_ACC;
            r.zero       <= RST_ZERO;
            r.pc         <= RST_PC;
        end else begin
            r <= next_r;
        end
    end

    assign acc             = r.acc;
    assign zero_flag       = r.zero;
    assign program_counter = r.pc;
    assign file_wr         = r.fwr;
    assign nop_cycle       = r.nop_cycle;
    assign retired         = r.retired;
    assign unknown_op      = r.unknown_op;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_dec_to_acc: assert property ( // RL1
        go && op_dec && !dest |=> acc == $past(file_rdata) - 8'h01)
        else $error("decrement result not in accumulator");

    a_dec_to_file: assert property ( // RL1
        go && op_dec && dest |=> file_wr.we && $stable(acc)
            && file_wr.addr == $past(fsel)
            && file_wr.data == $past(file_rdata) - 8'h01)
        else $error("decrement result not written to file");

    a_skip_inserts_nop: assert property ( // RL2
        go && op_dec && file_rdata == 8'h01
            |=> !nop_cycle ##1 nop_cycle && !retired)
        else $error("zero decrement did not insert nop");

    a_no_skip_nonzero: assert property ( // RL2
        go && (op_dec || op_inc) && !res_zero |=> r.phase == IDS_EXEC)
        else $error("nonzero result caused a skip");

    a_inc_skip_wrap: assert property ( // RL3
        go && op_inc && !dest && file_rdata == 8'hff
            |=> acc == 8'h00 ##1 nop_cycle)
        else $error("increment skip on wrap failed");

    a_skip_keeps_zero: assert property ( // RL3
        go && (op_dec || op_inc) |=> $stable(zero_flag))
        else $error("skip instruction changed zero flag");

    a_increment_file_zero: assert property ( // RL4
        go && op_increment_file |=> zero_flag == ($past(file_rdata) == 8'hff))
        else $error("increment zero flag wrong");

    a_jump_target: assert property ( // RL5
        go && op_jump |=> program_counter ==
            {$past(upper_jump_latch[PAGE_HI:PAGE_LO]), $past(jump_k)})
        else $error("jump target wrong");

    a_jump_two_cycles: assert property ( // RL6
        go && op_jump |=> $stable(zero_flag) && $stable(acc)
            ##1 nop_cycle && $stable(program_counter) && $stable(zero_flag))
        else $error("jump not two cycles or flags changed");

    a_or_literal: assert property ( // RL7
        go && op_iorl |=> acc == ($past(r.acc) | $past(lit))
            && zero_flag == (acc == 8'h00))
        else $error("or literal result or zero wrong");

    a_or_file: assert property ( // RL8
        go && op_iorf && dest |=> $stable(acc) && file_wr.we
            && file_wr.data == ($past(r.acc) | $past(file_rdata)))
        else $error("or with file result wrong");

    a_zero_clear: assert property ( // RL9
        go && (op_increment_file || op_iorf || op_iorl) && !res_zero |=> !zero_flag)
        else $error("zero flag not cleared on nonzero result");

    c_jump: cover property (go && op_jump ##2 nop_cycle);
    c_dec_skip: cover property (go && op_dec && res_zero ##2 nop_cycle);
    c_inc_no_skip: cover property (go && op_inc && !res_zero);
    c_or_zero: cover property (go && op_iorl && res_zero);

endmodule : ids_core

`default_nettype wire

/* File: hw/ids_pkg.sv */
/*
 * Constants, encodings and carrier types for the increment, decrement,
 * skip, jump and inclusive-OR execution slice.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package ids_pkg;

    // ==========================================================
    // Widths and field positions
    // ==========================================================
    localparam int INSTR_W   = 14;
    localparam int DATA_W    = 8;
    localparam int PC_W      = 13;
    localparam int FADDR_W   = 7;
    localparam int JUMP_K_W  = 11;
    localparam int DEST_BIT  = 7;
    localparam int OPC_LSB   = 8;
    localparam int JOPC_LSB  = 11;
    localparam int PAGE_HI   = 4;
    localparam int PAGE_LO   = 3;

    // ==========================================================
    // Opcode encodings
    // ==========================================================
    localparam logic [5:0] OP_DECREMENT_SKIP_ZERO = 6'h0b;
    localparam logic [5:0] OP_INCREMENT_SKIP_ZERO = 6'h0f;
    localparam logic [5:0] OP_INCREMENT_FILE      = 6'h0a;
    localparam logic [5:0] OP_OR_ACC_WITH_FILE    = 6'h04;
    localparam logic [5:0] OP_OR_LITERAL_ACC      = 6'h38;
    localparam logic [2:0] OP_JUMP_ABSOLUTE       = 3'h5;
    localparam logic       DEST_ACC               = 1'b0;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0]  RST_ACC  = 8'h00;
    localparam logic        RST_ZERO = 1'b0;
    localparam logic [12:0] RST_PC   = 13'h0000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic {IDS_EXEC, IDS_FLUSH} ids_phase_e;

    typedef struct packed {
        logic                  valid;
        logic [INSTR_W-1:0]    word;
    } ids_instr_s;

    typedef struct packed {
        logic                  we;
        logic [FADDR_W-1:0]    addr;
        logic [DATA_W-1:0]     data;
    } ids_fwr_s;

    typedef struct packed {
        ids_phase_e            phase;
        logic                  flush_inc;
        logic [DATA_W-1:0]     acc;
        logic                  zero;
        logic [PC_W-1:0]       pc;
        ids_fwr_s              fwr;
        logic                  nop_cycle;
        logic                  retired;
        logic                  unknown_op;
    } ids_state_s;

endpackage : ids_pkg

/* File: test/inc_dec_skip_jump_or_exec_tb_top.sv */
/*
 * Self-checking bench for the ids_core execution slice.
 * Assumes the bench plays the file register array and the jump latch.
 */
`timescale 1ns/1ps
`default_nettype none

module inc_dec_skip_jump_or_exec_tb_top
    import ids_pkg::*;
;
    logic                  mclk;
    logic                  resetn;
    ids_instr_s            instr;
    logic [DATA_W-1:0]     file_rdata;
    logic [DATA_W-1:0]     upper_jump_latch;
    logic [DATA_W-1:0]     acc;
    logic                  zero_flag;
    logic [PC_W-1:0]       program_counter;
    ids_fwr_s              file_wr;
    logic                  nop_cycle;
    logic                  retired;
    logic                  unknown_op;
    int                    n_fail;
    int                    n_checks;
    logic [PC_W-1:0]       pc_exp;
    logic [15:0]           fwr_seen;

    assign fwr_seen = {file_wr.we, file_wr.addr, file_wr.data};

    ids_core dut (
        .mclk(mclk), .resetn(resetn), .instr(instr),
        .file_rdata(file_rdata), .upper_jump_latch(upper_jump_latch),
        .acc(acc), .zero_flag(zero_flag),
        .program_counter(program_counter), .file_wr(file_wr),
        .nop_cycle(nop_cycle), .retired(retired), .unknown_op(unknown_op)
    );

    // ==========================================================
    // Clock, checking and closing
    // ==========================================================
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Shared drivers
    // ==========================================================
    // With keep set, the flush cycle is fed a harmful word to prove it is ignored
    task automatic op(input logic [13:0] w, input logic [7:0] fd,
                      input bit keep, input bit jmp);
        @(posedge mclk);
        instr      <= '{valid: 1'b1, word: w};
        file_rdata <= fd;
        @(posedge mclk);
        if (keep)
            instr.word <= {OP_OR_LITERAL_ACC, 8'hff};
        else
            instr.valid <= 1'b0;
        #1;
        chk(retired, 1'b1);
        if (!jmp) begin
            pc_exp++;
            chk(program_counter, pc_exp);
        end
    endtask : op

    task automatic flush(input logic [7:0] acc_exp, input bit pc_inc);
        @(posedge mclk);
        instr.valid <= 1'b0;
        #1;
        if (pc_inc)
            pc_exp++;
        chk(nop_cycle, 1'b1);
        chk(retired, 1'b0);
        chk(acc, acc_exp);
        chk(program_counter, pc_exp);
    endtask : flush

    function automatic logic [13:0] fw(logic [5:0] o, logic d, logic [6:0] f);
        return {o, d, f};
    endfunction : fw

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_or();
        op({OP_OR_LITERAL_ACC, 8'h00}, 8'h00, 0, 0);
        chk(acc, 8'h00);
        chk(zero_flag, 1'b1);
        op({OP_OR_LITERAL_ACC, 8'h5a}, 8'h00, 0, 0);
        chk(acc, 8'h5a);
        chk(zero_flag, 1'b0);
        op(fw(OP_OR_ACC_WITH_FILE, 1'b0, 7'h00), 8'ha5, 0, 0);
        chk(acc, 8'hff);
        op(fw(OP_OR_ACC_WITH_FILE, 1'b1, 7'h7f), 8'h00, 0, 0);
        chk(fwr_seen, {1'b1, 7'h7f, 8'hff});
        chk(acc, 8'hff);
        // Word outside this subset advances the program counter and raises unknown_op
        op({6'h00, 8'h00}, 8'h00, 0, 0);
        chk(unknown_op, 1'b1);
        chk(acc, 8'hff);
        $display("test or done");
    endtask : t_or

    task automatic t_increment_file();
        op(fw(OP_INCREMENT_FILE, 1'b0, 7'h10), 8'hff, 0, 0);
        chk(acc, 8'h00);
        chk(zero_flag, 1'b1);
        op(fw(OP_INCREMENT_FILE, 1'b1, 7'h7f), 8'h41, 0, 0);
        chk(fwr_seen, {1'b1, 7'h7f, 8'h42});
        chk(zero_flag, 1'b0);
        $display("test increment done");
    endtask : t_increment_file

    task automatic t_skip();
        op(fw(OP_DECREMENT_SKIP_ZERO, 1'b1, 7'h05), 8'h05, 0, 0);
        chk(fwr_seen, {1'b1, 7'h05, 8'h04});
        @(posedge mclk);
        #1;
        chk(nop_cycle, 1'b0);
        // Nonzero accumulator so the zero result below is visible
        op({OP_OR_LITERAL_ACC, 8'h3c}, 8'h00, 0, 0);
        chk(acc, 8'h3c);
        op(fw(OP_DECREMENT_SKIP_ZERO, 1'b0, 7'h01), 8'h01, 1, 0);
        chk(acc, 8'h00);
        chk(zero_flag, 1'b0);
        flush(8'h00, 1);
        op(fw(OP_INCREMENT_SKIP_ZERO, 1'b1, 7'h22), 8'hff, 1, 0);
        chk({file_wr.we, file_wr.data}, {1'b1, 8'h00});
        flush(8'h00, 1);
        op(fw(OP_INCREMENT_SKIP_ZERO, 1'b0, 7'h22), 8'h7f, 0, 0);
        chk(acc, 8'h80);
        @(posedge mclk);
        #1;
        chk(nop_cycle, 1'b0);
        $display("test skip done");
    endtask : t_skip

    task automatic t_jump();
        @(posedge mclk);
        upper_jump_latch <= 8'h18;
        op({OP_JUMP_ABSOLUTE, 11'h7ff}, 8'h00, 1, 1);
        pc_exp = 13'h1fff;
        chk(program_counter, pc_exp);
        chk(zero_flag, 1'b0);
        flush(8'h80, 0);
        @(posedge mclk);
        upper_jump_latch <= 8'he7;
        op({OP_JUMP_ABSOLUTE, 11'h000}, 8'h00, 0, 1);
        pc_exp = 13'h0000;
        chk(program_counter, pc_exp);
        chk(acc, 8'h80);
        $display("test jump done");
    endtask : t_jump

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        n_fail = 0;
        n_checks = 0;
        pc_exp = 13'h0000;
        resetn = 1'b0;
        instr = '0;
        file_rdata = 8'h00;
        upper_jump_latch = 8'h00;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_or();
        t_increment_file();
        t_skip();
        t_jump();
        end_of_test();
    end

    initial begin
        #20us;
        n_fail++;
        end_of_test();
    end

endmodule : inc_dec_skip_jump_or_exec_tb_top

`default_nettype wire
